// [rtl/pw_map.svh]
// register offsets, reset values and field positions of the pwm timer
`ifndef PW_MAP_SVH
`define PW_MAP_SVH

`define PW_OFS_ENABLE   8'h00
`define PW_OFS_POLARITY 8'h04
`define PW_OFS_CENTER   8'h08
`define PW_OFS_CONCAT   8'h0C
`define PW_OFS_PCM      8'h10
`define PW_OFS_LEVEL    8'h14
`define PW_OFS_PERIOD   8'h20
`define PW_OFS_DUTY     8'h40
`define PW_OFS_COUNT    8'h60
`define PW_ARRAY_MASK   8'hE0
`define PW_INDEX_LSB    2
`define PW_INDEX_MSB    4

`define PW_RST_ENABLE   8'h00
`define PW_RST_POLARITY 8'hFF
`define PW_RST_CENTER   8'h00
`define PW_RST_CONCAT   4'h0
`define PW_RST_PCM      8'h00
`define PW_RST_PERIOD   8'h00
`define PW_RST_DUTY     8'h00

`endif

// [rtl/pw_pkg.sv]
// types shared by the pwm timer
package pw_pkg;

    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] polarity;
        logic [7:0] center;
        logic [3:0] concat;
        logic [7:0] pcm;
    } pw_cfg_type;

    typedef struct packed {
        logic [15:0] cnt;
        logic        dn;
        logic        act;
    } pw_step_type;

endpackage : pw_pkg

// [rtl/pw_timer.sv]
// eight channel pwm timer with apb register slave
//
// Contract
// - eight channels, each with 8-bit period and duty settings.
// - each channel has its own counter, period and duty, independent.
// - each channel runs a continuous waveform independently once configured.
// - duty covers constantly inactive 0% through constantly active 100%.
// - selectable pcm output mode as alternative to pulse-width output.
// - software selects each output's active level, allowing inversion.
// - each output left aligned or center aligned about period middle.
// - pairs 7/6, 5/4, 3/2, 1/0 each joinable into one 16-bit channel.
`timescale 1ns/1ps
`include "pw_map.svh"

module pw_timer
    import pw_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [7:0]  pwm_out
);

    ////////////////////////////////////////////////////////////////////////
    // state

    pw_cfg_type  cfg;
    pw_cfg_type  next_cfg;
    logic [7:0]  period      [CHANNELS];
    logic [7:0]  next_period [CHANNELS];
    logic [7:0]  duty        [CHANNELS];
    logic [7:0]  next_duty   [CHANNELS];
    logic [7:0]  cnt         [CHANNELS];
    logic [7:0]  next_cnt    [CHANNELS];
    logic [7:0]  dn;
    logic [7:0]  next_dn;
    logic [7:0]  act;
    logic [7:0]  next_pwm_out;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    ////////////////////////////////////////////////////////////////////////
    // functions

    // one counter step, shared by 8-bit and joined 16-bit channels
    function automatic pw_step_type pw_step(
        input logic [15:0] c,
        input logic [15:0] p,
        input logic [15:0] d,
        input logic        ctr,
        input logic        pcm,
        input logic        down
    );
        pw_step_type s;
        logic [16:0] sum;
        s     = '0;
        s.cnt = c;
        s.dn  = down;
        sum   = {1'b0, c} + {1'b0, d};
        if (p == 16'h0000) begin
            s.cnt = 16'h0000;
            s.dn  = 1'b0;
        end else if (pcm) begin
            // accumulator: carry rate is duty over period
            if (d >= p) begin
                s.act = 1'b1;
            end else if (sum >= {1'b0, p}) begin
                s.act = 1'b1;
                s.cnt = 16'(sum - {1'b0, p});
            end else begin
                s.cnt = sum[15:0];
            end
        end else if (ctr) begin
            s.act = (d >= p) || ((d != 16'h0000) && (c > (p - d)));
            if (!down) begin
                if (c >= p) begin
                    s.cnt = p - 16'h0001;
                    s.dn  = 1'b1;
                end else begin
                    s.cnt = c + 16'h0001;
                end
            end else begin
                if (c == 16'h0000) begin
                    s.cnt = 16'h0001;
                    s.dn  = 1'b0;
                end else begin
                    s.cnt = c - 16'h0001;
                end
            end
        end else begin
            s.act = (d >= p) || (c < d);
            s.cnt = (c >= p - 16'h0001) ? 16'h0000 : c + 16'h0001;
            s.dn  = 1'b0;
        end
        return s;
    endfunction : pw_step

    function automatic logic pw_mapped(input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        if (a[1:0] == 2'h0) begin
            ok = (a <= `PW_OFS_LEVEL)
                || ((a & `PW_ARRAY_MASK) == `PW_OFS_PERIOD)
                || ((a & `PW_ARRAY_MASK) == `PW_OFS_DUTY)
                || ((a & `PW_ARRAY_MASK) == `PW_OFS_COUNT);
        end
        return ok;
    endfunction : pw_mapped

    ////////////////////////////////////////////////////////////////////////
    // register slave

    logic [2:0] idx;
    logic       wr_go;
    assign idx   = paddr[`PW_INDEX_MSB:`PW_INDEX_LSB];
    assign wr_go = psel && penable && pready && pwrite && !pslverr;

    always_comb begin
        next_cfg     = cfg;
        next_period  = period;
        next_duty    = duty;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        // no wait state: answer is ready in the first access cycle
        if (psel && !penable) begin
            next_pready  = 1'b1;
            next_pslverr = !pw_mapped(paddr);
            next_prdata  = 32'h0000_0000;
            if ((paddr & `PW_ARRAY_MASK) == `PW_OFS_PERIOD) begin
                next_prdata[7:0] = period[idx];
            end else if ((paddr & `PW_ARRAY_MASK) == `PW_OFS_DUTY) begin
                next_prdata[7:0] = duty[idx];
            end else if ((paddr & `PW_ARRAY_MASK) == `PW_OFS_COUNT) begin
                next_prdata[7:0] = cnt[idx];
            end else begin
                unique case (paddr)
                    `PW_OFS_ENABLE:   next_prdata[7:0] = cfg.enable;
                    `PW_OFS_POLARITY: next_prdata[7:0] = cfg.polarity;
                    `PW_OFS_CENTER:   next_prdata[7:0] = cfg.center;
                    `PW_OFS_CONCAT:   next_prdata[3:0] = cfg.concat;
                    `PW_OFS_PCM:      next_prdata[7:0] = cfg.pcm;
                    `PW_OFS_LEVEL:    next_prdata[7:0] = pwm_out;
                    default:          next_prdata      = 32'h0000_0000;
                endcase
            end
            // a refused address must not leak an array word
            if (next_pslverr) begin
                next_prdata = 32'h0000_0000;
            end
        end
        if (wr_go) begin
            if ((paddr & `PW_ARRAY_MASK) == `PW_OFS_PERIOD) begin
                next_period[idx] = pwdata[7:0];
            end else if ((paddr & `PW_ARRAY_MASK) == `PW_OFS_DUTY) begin
                next_duty[idx] = pwdata[7:0];
            end else begin
                unique case (paddr)
                    `PW_OFS_ENABLE:   next_cfg.enable   = pwdata[7:0];
                    `PW_OFS_POLARITY: next_cfg.polarity = pwdata[7:0];
                    `PW_OFS_CENTER:   next_cfg.center   = pwdata[7:0];
                    `PW_OFS_CONCAT:   next_cfg.concat   = pwdata[3:0];
                    `PW_OFS_PCM:      next_cfg.pcm      = pwdata[7:0];
                    default:          next_cfg          = cfg;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg.enable   <= `PW_RST_ENABLE;
            cfg.polarity <= `PW_RST_POLARITY;
            cfg.center   <= `PW_RST_CENTER;
            cfg.concat   <= `PW_RST_CONCAT;
            cfg.pcm      <= `PW_RST_PCM;
            for (int i = 0; i < CHANNELS; i++) begin
                period[i] <= `PW_RST_PERIOD;
                duty[i]   <= `PW_RST_DUTY;
            end
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            cfg     <= next_cfg;
            period  <= next_period;
            duty    <= next_duty;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channels

    always_comb begin
        pw_step_type s;
        int lo;
        int hi;
        s  = '0;
        lo = 0;
        hi = 0;
        next_cnt = cnt;
        next_dn  = dn;
        act      = 8'h00;
        next_pwm_out = 8'h00;
        for (int j = 0; j < CHANNELS; j++) begin
            s = pw_step({8'h00, cnt[j]}, {8'h00, period[j]},
                        {8'h00, duty[j]}, cfg.center[j], cfg.pcm[j],
                        dn[j]);
            next_cnt[j] = s.cnt[7:0];
            next_dn[j]  = s.dn;
            act[j]      = s.act;
        end
        for (int k = 0; k < CHANNELS / 2; k++) begin
            lo = 2 * k;
            hi = 2 * k + 1;
            if (cfg.concat[k]) begin
                // joined pair runs on the odd channel's controls
                s = pw_step({cnt[hi], cnt[lo]}, {period[hi], period[lo]},
                            {duty[hi], duty[lo]}, cfg.center[hi],
                            cfg.pcm[hi], dn[hi]);
                next_cnt[hi] = s.cnt[15:8];
                next_cnt[lo] = s.cnt[7:0];
                next_dn[hi]  = s.dn;
                next_dn[lo]  = 1'b0;
                act[hi]      = s.act;
                act[lo]      = 1'b0;
                if (!cfg.enable[hi]) begin
                    next_cnt[lo] = 8'h00;
                end
            end
        end
        for (int j = 0; j < CHANNELS; j++) begin
            // a joined low half keeps counting under the odd channel
            if (!cfg.enable[j] && !((j % 2 == 0) && cfg.concat[j / 2])) begin
                next_cnt[j] = 8'h00;
                next_dn[j]  = 1'b0;
                act[j]      = 1'b0;
            end
            next_pwm_out[j] = act[j] ~^ cfg.polarity[j];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < CHANNELS; i++) begin
                cnt[i] <= 8'h00;
            end
            dn      <= 8'h00;
            pwm_out <= 8'h00;
        end else if (ce) begin
            cnt     <= next_cnt;
            dn      <= next_dn;
            pwm_out <= next_pwm_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic plain0;
    logic plain1;
    assign plain0 = ce && cfg.enable[0] && !cfg.concat[0] && !cfg.pcm[0];
    assign plain1 = ce && cfg.enable[1] && !cfg.concat[0] && !cfg.pcm[1];

    sequence s_top_up;
        plain0 && cfg.center[0] && !dn[0] && (period[0] != 8'h00)
            && (cnt[0] == period[0]);
    endsequence

    sequence s_turn_down;
        dn[0] && (cnt[0] == $past(period[0]) - 8'h01);
    endsequence

    a_center_turn: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_top_up |=> s_turn_down)
        else $error("center count did not turn at the top");

    a_left_wrap: assert property (
        @(posedge mclk) disable iff (sys_rst)
        plain0 && !cfg.center[0] && (period[0] != 8'h00)
            && (cnt[0] >= period[0] - 8'h01) |=> cnt[0] == 8'h00)
        else $error("left count did not restart at period");

    a_duty_zero: assert property (
        @(posedge mclk) disable iff (sys_rst)
        plain1 && (duty[1] == 8'h00)
            |=> pwm_out[1] == !$past(cfg.polarity[1]))
        else $error("zero duty drove the active level");

    a_duty_full: assert property (
        @(posedge mclk) disable iff (sys_rst)
        plain1 && (period[1] != 8'h00) && (duty[1] >= period[1])
            |=> pwm_out[1] == $past(cfg.polarity[1]))
        else $error("full duty left the active level");

    a_pcm_full: assert property (
        @(posedge mclk) disable iff (sys_rst)
        ce && cfg.enable[2] && !cfg.concat[1] && cfg.pcm[2]
            && (period[2] != 8'h00) && (duty[2] >= period[2])
            |=> pwm_out[2] == $past(cfg.polarity[2]))
        else $error("pcm full duty not active");

    a_disabled_idle: assert property (
        @(posedge mclk) disable iff (sys_rst)
        ce && !cfg.enable[3] |=> (cnt[3] == 8'h00)
            && (pwm_out[3] == !$past(cfg.polarity[3])))
        else $error("disabled channel not idle");

    a_concat_low: assert property (
        @(posedge mclk) disable iff (sys_rst)
        ce && cfg.concat[0] |=> pwm_out[0] == !$past(cfg.polarity[0]))
        else $error("low half of joined pair not inactive");

    a_apb_ready: assert property (
        @(posedge mclk) disable iff (sys_rst)
        ce && psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

endmodule : pw_timer

// [bench/pw_timer_test.sv]
// self-checking random testbench of the eight channel pwm timer
`timescale 1ns/1ps
`include "pw_map.svh"

module pw_timer_test
    import pw_pkg::*;
;
    logic        mclk     = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        ce       = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pwm_out;
    int          failures = 0;
    int          checked  = 0;
    int          seed     = 32'hB73E;
    int          act [8];
    int          tg [8];
    int          per [8];
    int          dut [8];
    logic [31:0] rd;
    logic        er;
    logic [31:0] v;
    logic [7:0]  pol;
    logic [7:0]  ctr;
    logic [7:0]  pcm;

    always #12.5 mclk = ~mclk;

    pw_timer pw_timer_i (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_out(pwm_out));

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("counts: %0d checked, %0d failures", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp,
                           input string m);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got,
                     exp);
        end
    endtask : chk_reg

    task automatic chk_cnt(input int got, input int exp, input string m);
        checked++;
        if (got != exp) begin
            failures++;
            $display("mismatch at %0t: %s got %0d want %0d", $time, m, got,
                     exp);
        end
    endtask : chk_cnt

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: no pready", $time);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // active cycles and level changes of every pin over w cycles
    task automatic sample(input int w);
        logic [7:0] prev;
        prev = pwm_out;
        for (int i = 0; i < 8; i++) begin
            act[i] = 0;
            tg[i] = 0;
        end
        repeat (w) begin
            @(posedge mclk);
            for (int i = 0; i < 8; i++) begin
                act[i] += (pwm_out[i] === pol[i]);
                tg[i] += (pwm_out[i] !== prev[i]);
            end
            prev = pwm_out;
        end
    endtask : sample

    // channels stopped while reprogrammed so counters restart cleanly
    task automatic setup(input logic [7:0] en);
        apb(1'b1, `PW_OFS_ENABLE, 32'h0);
        apb(1'b1, `PW_OFS_POLARITY, {24'h0, pol});
        apb(1'b1, `PW_OFS_CENTER, {24'h0, ctr});
        apb(1'b1, `PW_OFS_PCM, {24'h0, pcm});
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 8'(`PW_OFS_PERIOD + 4 * i), 32'(per[i]));
            apb(1'b1, 8'(`PW_OFS_DUTY + 4 * i), 32'(dut[i]));
        end
        apb(1'b1, `PW_OFS_ENABLE, {24'h0, en});
        repeat (80) @(posedge mclk);
        sample(256);
    endtask : setup

    function automatic int on_cycles(int p, int d, int w);
        return (p == 0) ? 0 : ((d >= p) ? p : d) * (w / p);
    endfunction : on_cycles

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge mclk);
        failures++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        chk_reg(32'(pwm_out), 32'h0, "pins after reset");
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk_reg(rd, (i == 1) ? 32'hFF : 32'h0, "reset control");
        end
        for (int i = 0; i < 24; i++) begin
            apb(1'b0, 8'(`PW_OFS_PERIOD + 4 * i), 32'h0);
            chk_reg(rd, 32'h0, "reset array");
        end
        for (int i = 0; i < 13; i++) begin
            v = $random(seed);
            apb(1'b1, 8'(4 * i + ((i < 5) ? 0 : 12)), v);
            apb(1'b0, 8'(4 * i + ((i < 5) ? 0 : 12)), 32'h0);
            chk_reg(rd, v & ((i == 3) ? 32'hF : 32'hFF), "readback");
            apb(1'b1, 8'(4 * i + ((i < 5) ? 0 : 12)), 32'h0);
        end
        apb(1'b1, `PW_OFS_COUNT, 32'hFF);
        apb(1'b0, `PW_OFS_COUNT, 32'h0);
        chk_reg(rd, 32'h0, "counter write ignored");
        apb(1'b0, 8'h18, 32'h0);
        chk_reg({rd[30:0], er}, 32'h1, "unmapped read");
        apb(1'b1, 8'h23, 32'hFF);
        chk_reg(32'(er), 32'h1, "unaligned write");
        $display("test registers done");
        pol = $random(seed);
        ctr = 8'h00;
        pcm = 8'h00;
        for (int i = 0; i < 8; i++) begin
            per[i] = 4 << ($unsigned($random(seed)) % 4);
            dut[i] = $unsigned($random(seed)) % (per[i] + 3);
        end
        dut[0] = 0;
        dut[1] = per[1];
        per[7] = 0;
        setup(8'hFF);
        for (int i = 0; i < 8; i++) begin
            chk_cnt(act[i], on_cycles(per[i], dut[i], 256), "duty");
        end
        $display("test duty done");
        ctr = $random(seed);
        pcm = $random(seed) & ~ctr;
        for (int i = 0; i < 8; i++) begin
            dut[i] = per[i] / 2;
        end
        per[7] = 16;
        dut[7] = 8;
        setup(8'hFF);
        for (int i = 0; i < 8; i++) begin
            if (ctr[i]) begin
                chk_cnt(tg[i], 256 / per[i], "center changes");
            end else if (pcm[i]) begin
                chk_cnt(tg[i], 256, "pcm changes");
            end else begin
                chk_cnt(tg[i], 512 / per[i], "left changes");
            end
        end
        @(posedge mclk);
        ce <= 1'b0;
        @(posedge mclk);
        v = {24'h0, pwm_out};
        repeat (20) @(posedge mclk);
        chk_reg({24'h0, pwm_out}, v, "frozen pins");
        ce <= 1'b1;
        $display("test modes done");
        pol = 8'hFF;
        ctr = 8'h00;
        pcm = 8'h00;
        for (int i = 0; i < 8; i++) begin
            per[i] = 0;
            dut[i] = 0;
        end
        per[1] = 1;
        dut[0] = 8'h40;
        apb(1'b1, `PW_OFS_CONCAT, 32'h1);
        setup(8'h02);
        chk_cnt(act[1], 64, "wide channel duty");
        chk_cnt(act[0], 0, "joined low pin idle");
        apb(1'b1, `PW_OFS_ENABLE, 32'h0);
        apb(1'b1, `PW_OFS_POLARITY, 32'h0F);
        apb(1'b0, `PW_OFS_LEVEL, 32'h0);
        chk_reg(rd, 32'hF0, "pin levels");
        apb(1'b1, `PW_OFS_CONCAT, 32'h0);
        $display("test concat done");
        conclude();
    end
endmodule : pw_timer_test
